// [hdl/bfhp_cfg.svh]
`ifndef BFHP_CFG_SVH
`define BFHP_CFG_SVH

// ==========================================================
// Widths and depths
`define BFHP_DATA_W 8
`define BFHP_PTR_W 3
`define BFHP_CNT_W 4
`define BFHP_BUF_FULL 4'h8
`define BFHP_TIMER_W 20
`define BFHP_SYNC_W 12

// ==========================================================
// Timing
`define BFHP_CLK_HZ 20000000
`define BFHP_TX_TIMEOUT_MS 16
`define BFHP_WAKE_MIN_MS 20
`define BFHP_TX_TIMEOUT_CYC ((`BFHP_CLK_HZ / 1000) * `BFHP_TX_TIMEOUT_MS)
`define BFHP_WAKE_MIN_CYC ((`BFHP_CLK_HZ * `BFHP_WAKE_MIN_MS + 999) / 1000)

// ==========================================================
// Reset values
`define BFHP_SYNC_RST 12'hFFF

`endif

// [hdl/bfhp_pkg.sv]
`include "bfhp_cfg.svh"

package bfhp_pkg;
    typedef logic [`BFHP_DATA_W-1:0] bfhp_byte_t;
    typedef logic [`BFHP_CNT_W-1:0] bfhp_cnt_t;
    typedef logic [`BFHP_PTR_W-1:0] bfhp_ptr_t;
    typedef enum logic [1:0] {
        BFHP_IDLE = 2'b01,
        BFHP_DRAIN = 2'b10
    } bfhp_tx_e;
endpackage

// [hdl/bfhp_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module bfhp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_dout;

    // A bit changes only once the second and third stages agree.
    always_comb begin
        next_dout = dout;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_dout[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
            dout <= RST;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule // bfhp_sync

`default_nettype wire

// [hdl/bfhp_top.sv]
// What this block does
// - A falling write strobe samples the eight data lines and appends the byte to the transmit buffer.
// - Buffered transmit bytes are forwarded before the 16 ms transmit timeout expires.
// - While the read strobe is low the current receive byte is driven on the data lines.
// - A rising read strobe releases the data lines and advances the receive buffer.
// - Both flag pins are undriven while the block is in reset.
// - The receive flag is low while any byte waits and high when the receive buffer is empty.
// - In suspend with remote wakeup on, the receive flag pin is an input and a 20 ms low requests resume.
// - The data bus is eight bits, bit 7 most significant, shared by both directions.
// - Interface inputs pass through synchronisers on the system clock; the interface clock driven out is that clock divided by two.
// - A send-now low pulse in normal operation flushes pending transmit data on the next bulk-in request.
`timescale 1ns/100ps
`default_nettype none
`include "bfhp_cfg.svh"

module bfhp_top #(
    parameter logic [`BFHP_TIMER_W-1:0] TX_TIMEOUT_CYC = `BFHP_TIMER_W'(`BFHP_TX_TIMEOUT_CYC),
    parameter logic [`BFHP_TIMER_W-1:0] WAKE_MIN_CYC = `BFHP_TIMER_W'(`BFHP_WAKE_MIN_CYC)
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic wrStrobeN,
    input wire logic rdStrobeN,
    input wire bfhp_pkg::bfhp_byte_t busIn,
    output bfhp_pkg::bfhp_byte_t busOut,
    output logic busOe,
    output logic txSpaceFlagN,
    output logic txSpaceFlagOe,
    input wire logic rxDataFlagNIn,
    output logic rxDataFlagN,
    output logic rxDataFlagOe,
    input wire logic sendNowWakeInput,
    input wire logic powerEnableIndicatorN,
    input wire logic remoteWakeEnable,
    output logic resumeRequest,
    input wire logic bulkInRequest,
    output bfhp_pkg::bfhp_byte_t txOutData,
    output logic txOutValid,
    input wire bfhp_pkg::bfhp_byte_t rxInData,
    input wire logic rxInValid,
    output logic rxInReady,
    output logic interfaceClockOut
);
    import bfhp_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic wrSyn, rdSyn, snSyn, rxPinSyn;
    bfhp_byte_t busSyn;
    logic wrPrev, rdPrev, snPrev;

    bfhp_sync #(.W(`BFHP_SYNC_W), .RST(`BFHP_SYNC_RST)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .din({wrStrobeN, rdStrobeN, sendNowWakeInput, rxDataFlagNIn, busIn}),
        .dout({wrSyn, rdSyn, snSyn, rxPinSyn, busSyn})
    );

    wire logic wrFalls = wrPrev & ~wrSyn;
    wire logic rdRises = ~rdPrev & rdSyn;
    wire logic snFalls = snPrev & ~snSyn;
    wire logic suspended = powerEnableIndicatorN;
    wire logic wakeArmed = suspended & remoteWakeEnable;

    // ==========================================================
    // Transmit buffer and flush control
    bfhp_byte_t txMem [`BFHP_BUF_FULL];
    bfhp_ptr_t txWp, txRp, next_txWp, next_txRp;
    bfhp_cnt_t txCnt, next_txCnt;
    bfhp_tx_e txState, next_txState;
    logic [`BFHP_TIMER_W-1:0] txTimer, next_txTimer;
    logic sendNowPend, next_sendNowPend;
    logic txPush, txPop, goDrain;
    bfhp_byte_t next_txOutData;
    logic next_txOutValid, next_txSpaceFlagN;

    always_comb begin
        txPush = wrFalls && (txCnt != `BFHP_BUF_FULL);
        txPop = (txState == BFHP_DRAIN) && (txCnt != '0);
        goDrain = (txState == BFHP_IDLE) && (txCnt != '0)
            && ((txTimer >= TX_TIMEOUT_CYC - 1'b1) || (txCnt == `BFHP_BUF_FULL)
            || (sendNowPend && bulkInRequest));
        next_txWp = txPush ? txWp + 1'b1 : txWp;
        next_txRp = txPop ? txRp + 1'b1 : txRp;
        next_txCnt = txCnt + bfhp_cnt_t'(txPush) - bfhp_cnt_t'(txPop);
        next_txOutValid = txPop;
        next_txOutData = txPop ? txMem[txRp] : txOutData;
        case (txState)
            BFHP_IDLE: begin
                next_txState = goDrain ? BFHP_DRAIN : BFHP_IDLE;
            end
            BFHP_DRAIN: begin
                next_txState = (next_txCnt == '0) ? BFHP_IDLE : BFHP_DRAIN;
            end
            default: begin
                next_txState = BFHP_IDLE;
            end
        endcase
        if (txCnt == '0 || txState == BFHP_DRAIN || goDrain) begin
            next_txTimer = '0;
        end else begin
            next_txTimer = txTimer + 1'b1;
        end
        // send-now latch, a new pulse wins over the clear
        next_sendNowPend = sendNowPend;
        if (bulkInRequest) begin
            next_sendNowPend = 1'b0;
        end
        if (snFalls && !suspended) begin
            next_sendNowPend = 1'b1;
        end
        // full buffer raises the space flag
        next_txSpaceFlagN = (next_txCnt == `BFHP_BUF_FULL);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txWp <= '0;
            txRp <= '0;
            txCnt <= '0;
            txState <= BFHP_IDLE;
            txTimer <= '0;
            sendNowPend <= 1'b0;
            txOutValid <= 1'b0;
            txOutData <= 8'h00;
            txSpaceFlagN <= 1'b1;
        end else if (ce) begin
            txWp <= next_txWp;
            txRp <= next_txRp;
            txCnt <= next_txCnt;
            txState <= next_txState;
            txTimer <= next_txTimer;
            sendNowPend <= next_sendNowPend;
            txOutValid <= next_txOutValid;
            txOutData <= next_txOutData;
            txSpaceFlagN <= next_txSpaceFlagN;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && txPush) begin
            txMem[txWp] <= busSyn;
        end
    end

    // ==========================================================
    // Receive buffer and data bus
    bfhp_byte_t rxMem [`BFHP_BUF_FULL];
    bfhp_ptr_t rxWp, rxRp, next_rxWp, next_rxRp;
    bfhp_cnt_t rxCnt, next_rxCnt;
    logic rxPush, rxPop;
    bfhp_byte_t next_busOut;
    logic next_busOe, next_rxDataFlagN, next_rxInReady;

    always_comb begin
        rxPush = rxInValid && rxInReady;
        rxPop = rdRises && (rxCnt != '0);
        next_rxWp = rxPush ? rxWp + 1'b1 : rxWp;
        next_rxRp = rxPop ? rxRp + 1'b1 : rxRp;
        next_rxCnt = rxCnt + bfhp_cnt_t'(rxPush) - bfhp_cnt_t'(rxPop);
        // head byte, bypassed when it lands this cycle
        if (rxPush && (next_rxRp == rxWp)) begin
            next_busOut = rxInData;
        end else begin
            next_busOut = rxMem[next_rxRp];
        end
        // drive only while the strobe is low
        next_busOe = ~rdSyn;
        next_rxDataFlagN = (next_rxCnt == '0);
        next_rxInReady = (next_rxCnt != `BFHP_BUF_FULL);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rxWp <= '0;
            rxRp <= '0;
            rxCnt <= '0;
            busOut <= 8'h00;
            busOe <= 1'b0;
            rxDataFlagN <= 1'b1;
            rxInReady <= 1'b0;
            wrPrev <= 1'b1;
            rdPrev <= 1'b1;
            snPrev <= 1'b1;
        end else if (ce) begin
            rxWp <= next_rxWp;
            rxRp <= next_rxRp;
            rxCnt <= next_rxCnt;
            busOut <= next_busOut;
            busOe <= next_busOe;
            rxDataFlagN <= next_rxDataFlagN;
            rxInReady <= next_rxInReady;
            wrPrev <= wrSyn;
            rdPrev <= rdSyn;
            snPrev <= snSyn;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && rxPush) begin
            rxMem[rxWp] <= rxInData;
        end
    end

    // ==========================================================
    // Flag pin drive, remote wakeup and interface clock
    logic [`BFHP_TIMER_W-1:0] wakeCnt, next_wakeCnt;
    logic next_resumeRequest, next_txSpaceFlagOe, next_rxDataFlagOe;

    always_comb begin
        // flags leave tri-state only after reset
        next_txSpaceFlagOe = 1'b1;
        // receive flag pin turns input in armed suspend
        next_rxDataFlagOe = ~wakeArmed;
        if (!wakeArmed || rxPinSyn) begin
            next_wakeCnt = '0;
        end else if (wakeCnt != WAKE_MIN_CYC) begin
            next_wakeCnt = wakeCnt + 1'b1;
        end else begin
            next_wakeCnt = wakeCnt;
        end
        // one resume pulse per long low
        next_resumeRequest = wakeArmed && !rxPinSyn && (wakeCnt == WAKE_MIN_CYC - 1'b1);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txSpaceFlagOe <= 1'b0;
            rxDataFlagOe <= 1'b0;
            wakeCnt <= '0;
            resumeRequest <= 1'b0;
            interfaceClockOut <= 1'b0;
        end else if (ce) begin
            txSpaceFlagOe <= next_txSpaceFlagOe;
            rxDataFlagOe <= next_rxDataFlagOe;
            wakeCnt <= next_wakeCnt;
            resumeRequest <= next_resumeRequest;
            // interface clock divided from the system clock
            interfaceClockOut <= ~interfaceClockOut;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_tx_append;
        ce && wrFalls && (txCnt != `BFHP_BUF_FULL) |=> txMem[$past(txWp)] == $past(busSyn);
    endproperty
    a_tx_append: assert property (p_tx_append) else $error("write byte not stored");

    property p_tx_timeout;
        txState == BFHP_IDLE |-> txTimer < TX_TIMEOUT_CYC;
    endproperty
    a_tx_timeout: assert property (p_tx_timeout) else $error("transmit timeout overrun");

    property p_bus_drive;
        ce && !rdSyn |=> busOe;
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("bus not driven in read");

    property p_rx_advance;
        ce && rdRises && (rxCnt != '0) |=> !busOe && (rxRp == $past(rxRp) + 1'b1);
    endproperty
    a_rx_advance: assert property (p_rx_advance) else $error("read did not advance");

    property p_flags_tristate;
        @(posedge clk_sys) disable iff (1'b0) !rstn |-> !txSpaceFlagOe && !rxDataFlagOe;
    endproperty
    a_flags_tristate: assert property (p_flags_tristate) else $error("flag driven in reset");

    property p_rx_flag;
        (rxCnt != '0) |-> !rxDataFlagN;
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("receive flag high with data");

    property p_resume;
        resumeRequest |-> $past(wakeCnt) == WAKE_MIN_CYC - 1'b1 && !rxDataFlagOe;
    endproperty
    a_resume: assert property (p_resume) else $error("resume without 20 ms low");

    property p_bus_head;
        (rxCnt != '0) |-> busOut == rxMem[rxRp];
    endproperty
    a_bus_head: assert property (p_bus_head) else $error("bus byte not buffer head");

    property p_send_now;
        ce && sendNowPend && bulkInRequest && (txState == BFHP_IDLE) && (txCnt != '0)
            |=> txState == BFHP_DRAIN ##1 txOutValid;
    endproperty
    a_send_now: assert property (p_send_now) else $error("send-now did not flush");

    property p_last_read;
        ce && rxPop && (rxCnt == 4'h1) && !rxPush |=> rxDataFlagN;
    endproperty
    a_last_read: assert property (p_last_read) else $error("flag not raised after last read");
endmodule // bfhp_top

`default_nettype wire

// [test/bfhp_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none

module bfhp_ctrl_model (
    input wire logic clk_sys,
    input wire bfhp_pkg::bfhp_byte_t busOut,
    input wire logic busOe,
    input wire logic txSpaceFlagN,
    output logic wrStrobeN,
    output logic rdStrobeN,
    output bfhp_pkg::bfhp_byte_t busIn
);
    import bfhp_pkg::*;
    bfhp_byte_t drv;
    logic own;
    initial begin
        drv = 8'h00;
        own = 1'b1;
        wrStrobeN = 1'b1;
        rdStrobeN = 1'b1;
    end
    // ==========================================================
    // Shared bus level
    // one shared bus
    // A bus driven by neither side shows the inverse of the last byte the controller drove.
    assign busIn = busOe ? busOut : (own ? drv : ~drv);

    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic writeByte(input bfhp_byte_t b);
        int k;
        k = 0;
        while (txSpaceFlagN !== 1'b0 && k < 200) begin
            hold(1);
            k++;
        end
        own = 1'b1;
        drv = b;
        hold(1);
        wrStrobeN = 1'b0;
        hold(5);
        wrStrobeN = 1'b1;
        hold(3);
    endtask

    task automatic readByte(output bfhp_byte_t b);
        own = 1'b0;
        hold(2);
        rdStrobeN = 1'b0;
        hold(6);
        b = busIn;
        rdStrobeN = 1'b1;
        hold(6);
    endtask
endmodule // bfhp_ctrl_model

`default_nettype wire

// [test/byte_fifo_host_port_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module byte_fifo_host_port_tb;
    import bfhp_pkg::*;
    localparam int TMO = 40;
    logic clk_sys = 1'b0;
    logic rstn = 1'b1;
    logic clkEn = 1'b1;
    logic sendNow = 1'b1;
    logic pwrN = 1'b0;
    logic wakeEn = 1'b0;
    logic bulkReq = 1'b0;
    logic rxValid = 1'b0;
    logic wakePin = 1'b1;
    bfhp_byte_t rxData = 8'h00;
    logic wrN, rdN, busOe, txN, txOe, rxN, rxOe, rxPin, resume, txValid, rxReady;
    logic interface_clock_out;
    bfhp_byte_t busIn, busOut, txData, b;
    bfhp_byte_t expQ[$];
    bfhp_byte_t gotQ[$];
    bfhp_byte_t rxQ[$];
    int n_errors = 0;
    int tests_run = 0;
    int nResume = 0;

    always #25 clk_sys = ~clk_sys;
    assign rxPin = rxOe ? rxN : wakePin;

    bfhp_top #(.TX_TIMEOUT_CYC(20'h28), .WAKE_MIN_CYC(20'h1E)) uut (
        .clk_sys(clk_sys), .rstn(rstn), .ce(clkEn), .wrStrobeN(wrN), .rdStrobeN(rdN),
        .busIn(busIn), .busOut(busOut), .busOe(busOe), .txSpaceFlagN(txN),
        .txSpaceFlagOe(txOe), .rxDataFlagNIn(rxPin), .rxDataFlagN(rxN), .rxDataFlagOe(rxOe),
        .sendNowWakeInput(sendNow), .powerEnableIndicatorN(pwrN),
        .remoteWakeEnable(wakeEn), .resumeRequest(resume), .bulkInRequest(bulkReq),
        .txOutData(txData), .txOutValid(txValid), .rxInData(rxData), .rxInValid(rxValid),
        .rxInReady(rxReady), .interfaceClockOut(interface_clock_out)
    );
    bfhp_ctrl_model ctrl (
        .clk_sys(clk_sys), .busOut(busOut), .busOe(busOe), .txSpaceFlagN(txN),
        .wrStrobeN(wrN), .rdStrobeN(rdN), .busIn(busIn)
    );

    // ==========================================================
    // Far-side sinks
    always @(negedge clk_sys) begin
        if (txValid === 1'b1) gotQ.push_back(txData);
        if (resume === 1'b1) nResume++;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chkByte(input bfhp_byte_t got, input bfhp_byte_t exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        chkByte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input int n);
        repeat (n) begin
            b = bfhp_byte_t'($urandom);
            expQ.push_back(b);
            ctrl.writeByte(b);
        end
    endtask
    task automatic drain(input int lim);
        int k;
        k = 0;
        while (gotQ.size() < expQ.size() && k < lim) begin
            hold(1);
            k++;
        end
        chkByte(8'(gotQ.size()), 8'(expQ.size()));
        while (gotQ.size() > 0 && expQ.size() > 0) chkByte(gotQ.pop_front(), expQ.pop_front());
        gotQ.delete();
        expQ.delete();
    endtask
    task automatic doReset();
        hold(1);
        rstn = 1'b0;
        hold(6);
        chkBit(txOe, 1'b0);
        chkBit(rxOe, 1'b0);
        rstn = 1'b1;
        hold(4);
        chkBit(txOe, 1'b1);
        chkBit(txN, 1'b0);
        chkBit(rxN, 1'b1);
        chkBit(interface_clock_out, 1'b0);
        hold(1);
        chkBit(interface_clock_out, 1'b1);
        $display("test reset done");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hA61F2ECE));
        doReset();
        wr(3);
        drain(TMO + 30);
        $display("test timeout drain done");
        wr(9);
        drain(TMO + 30);
        $display("test burst drain done");
        wr(1);
        sendNow = 1'b0;
        hold(4);
        sendNow = 1'b1;
        hold(5);
        bulkReq = 1'b1;
        hold(1);
        bulkReq = 1'b0;
        drain(8);
        $display("test send now done");
        rxValid = 1'b1;
        for (int i = 0; i < 8; i++) begin
            while (rxReady !== 1'b1) hold(1);
            rxData = bfhp_byte_t'($urandom);
            rxQ.push_back(rxData);
            hold(1);
        end
        rxValid = 1'b0;
        hold(2);
        chkBit(rxReady, 1'b0);
        chkBit(rxN, 1'b0);
        chkBit(busOe, 1'b0);
        while (rxQ.size() > 0) begin
            ctrl.readByte(b);
            chkByte(b, rxQ.pop_front());
        end
        chkBit(rxN, 1'b1);
        chkBit(busOe, 1'b0);
        $display("test receive done");
        pwrN = 1'b1;
        wakeEn = 1'b1;
        hold(3);
        chkBit(rxOe, 1'b0);
        wakePin = 1'b0;
        hold(10);
        wakePin = 1'b1;
        hold(10);
        chkByte(8'(nResume), 8'h00);
        wakePin = 1'b0;
        hold(45);
        wakePin = 1'b1;
        hold(5);
        chkByte(8'(nResume), 8'h01);
        pwrN = 1'b0;
        hold(3);
        chkBit(rxOe, 1'b1);
        $display("test wake done");
        rxData = bfhp_byte_t'($urandom);
        rxValid = 1'b1;
        clkEn = 1'b0;
        b = {7'h00, interface_clock_out};
        hold(4);
        chkBit(interface_clock_out, b[0]);
        chkBit(rxN, 1'b1);
        rxValid = 1'b0;
        clkEn = 1'b1;
        hold(2);
        chkBit(rxN, 1'b1);
        $display("test clock enable done");
        doReset();
        results();
    end
endmodule // byte_fifo_host_port_tb

`default_nettype wire
